//--- core/irq_prio_pkg.sv
// constants and carrier types for the extended interrupt enable and priority block
package irq_prio_pkg;

    // ********************************
    // special-function register map
    // ********************************
    localparam logic [7:0] ADDR_FIRST_GROUP_PRIORITY_HIGH = 8'h85;
    localparam logic [7:0] ADDR_SECOND_GROUP_PRIORITY_HIGH = 8'h86;
    localparam logic [7:0] ADDR_SECOND_GROUP_ENABLE = 8'haf;
    localparam logic [7:0] ADDR_SECOND_GROUP_PRIORITY_LOW = 8'hbf;
    localparam logic [7:0] ADDR_FIRST_GROUP_PRIORITY_LOW = 8'hf6;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ********************************
    // field positions
    // ********************************
    // first group: bit 6 is reserved
    localparam int BIT_TIMER3 = 7;
    localparam int BIT_COMPARATOR = 5;
    localparam int BIT_COUNTER_ARRAY = 4;
    localparam int BIT_CONVERSION_DONE = 3;
    localparam int BIT_WINDOW_COMPARE = 2;
    localparam int BIT_PORT_MATCH = 1;
    localparam int BIT_SERIAL_BUS_A = 0;
    // second group: bits 7:4 reserved
    localparam int BIT_TEMP_SENSOR = 3;
    localparam int BIT_TIMER5 = 2;
    localparam int BIT_TIMER4 = 1;
    localparam int BIT_SERIAL_BUS_B = 0;

    // ********************************
    // source numbering, lowest wins a tie
    // ********************************
    localparam int NUM_SOURCES = 11;
    localparam int NUM_LEVELS = 4;
    localparam logic [3:0] SRC_SERIAL_BUS_A = 4'h0;
    localparam logic [3:0] SRC_PORT_MATCH = 4'h1;
    localparam logic [3:0] SRC_WINDOW_COMPARE = 4'h2;
    localparam logic [3:0] SRC_CONVERSION_DONE = 4'h3;
    localparam logic [3:0] SRC_COUNTER_ARRAY = 4'h4;
    localparam logic [3:0] SRC_COMPARATOR = 4'h5;
    localparam logic [3:0] SRC_TIMER3 = 4'h6;
    localparam logic [3:0] SRC_SERIAL_BUS_B = 4'h7;
    localparam logic [3:0] SRC_TIMER4 = 4'h8;
    localparam logic [3:0] SRC_TIMER5 = 4'h9;
    localparam logic [3:0] SRC_TEMP_SENSOR = 4'ha;

    // ********************************
    // carriers
    // ********************************
    typedef struct packed {
        logic timer3;
        logic comparator;
        logic counter_array;
        logic conversion_done;
        logic window_compare;
        logic port_match;
        logic serial_bus_a;
    } first_group_req_t;

    typedef struct packed {
        logic temp_sensor;
        logic timer5_low_overflow_flag;
        logic timer5_high_overflow_flag;
        logic timer4_low_overflow_flag;
        logic timer4_high_overflow_flag;
        logic serial_bus_b;
    } second_group_req_t;

    typedef struct packed {
        logic valid;
        logic [3:0] source;
        logic [1:0] level;
    } irq_req_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_access_t;

endpackage

//--- core/extended_irq_enable_priority.sv
// extended interrupt enable, four-level priority registers and request arbiter
//
// Summary of operation
// - timer5 enable bit 2 of the second enable register passes either timer5 flag, else masks.
// - timer4 enable bit 1 of the second enable register passes either timer4 flag, else masks.
// - serial bus b enable bit 0 of the second enable register passes or masks its requests.
// - temperature sensor enable bit 3 of the second enable register passes or masks it.
// - first high priority register holds the level MSB of the seven first-group sources.
// - second low priority register holds the level LSB of the four second-group sources.
// - second high priority register holds the level MSB of the four second-group sources.
// - every register decodes at its fixed address regardless of the selected page.
// - first low priority register holds the level LSB of the first-group sources, same bits.
module extended_irq_enable_priority
    import irq_prio_pkg::*;
(
    input wire logic i_ref_clk,                       // system clock, 125 MHz
    input wire logic i_sys_rst,                       // synchronous reset, active high
    input wire sfr_access_t i_sfr,                    // register access from the core
    input wire logic [7:0] i_first_group_enable,      // first-group enables, held elsewhere
    input wire first_group_req_t i_first_group_req,   // first-group pending requests
    input wire second_group_req_t i_second_group_req, // second-group pending flags
    output logic [7:0] o_sfr_rdata,                   // read data, one cycle after read
    output logic o_sfr_hit,                           // read addressed a register here
    output irq_req_t o_irq                            // winning request to the core
);

    // ********************************
    // registers
    // ********************************
    logic [7:0] first_group_priority_high;
    logic [7:0] first_group_priority_low;
    logic [7:0] second_group_enable;
    logic [7:0] second_group_priority_low;
    logic [7:0] second_group_priority_high;

    // no page input at all: the decode cannot depend on it
    wire sel_fph = (i_sfr.addr == ADDR_FIRST_GROUP_PRIORITY_HIGH);
    wire sel_fpl = (i_sfr.addr == ADDR_FIRST_GROUP_PRIORITY_LOW);
    wire sel_sen = (i_sfr.addr == ADDR_SECOND_GROUP_ENABLE);
    wire sel_spl = (i_sfr.addr == ADDR_SECOND_GROUP_PRIORITY_LOW);
    wire sel_sph = (i_sfr.addr == ADDR_SECOND_GROUP_PRIORITY_HIGH);
    wire any_sel = sel_fph | sel_fpl | sel_sen | sel_spl | sel_sph;

    // one write strobe per register keeps each storage process short
    wire wr_fph = i_sfr.wr & sel_fph;
    wire wr_fpl = i_sfr.wr & sel_fpl;
    wire wr_sen = i_sfr.wr & sel_sen;
    wire wr_spl = i_sfr.wr & sel_spl;
    wire wr_sph = i_sfr.wr & sel_sph;

    // reserved bits are stored as written; hardware ignores them, so a
    // nonzero write there is harmless but reads back
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            first_group_priority_high <= REG_RESET;
        end else if (wr_fph) begin
            first_group_priority_high <= i_sfr.wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            first_group_priority_low <= REG_RESET;
        end else if (wr_fpl) begin
            first_group_priority_low <= i_sfr.wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            second_group_enable <= REG_RESET;
        end else if (wr_sen) begin
            second_group_enable <= i_sfr.wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            second_group_priority_low <= REG_RESET;
        end else if (wr_spl) begin
            second_group_priority_low <= i_sfr.wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            second_group_priority_high <= REG_RESET;
        end else if (wr_sph) begin
            second_group_priority_high <= i_sfr.wdata;
        end
    end

    // ********************************
    // read path
    // ********************************
    wire [7:0] next_sfr_rdata = sel_fph ? first_group_priority_high :
                                sel_fpl ? first_group_priority_low :
                                sel_sen ? second_group_enable :
                                sel_spl ? second_group_priority_low :
                                sel_sph ? second_group_priority_high : READ_UNMAPPED;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_sfr_rdata <= READ_UNMAPPED;
        end else begin
            o_sfr_rdata <= i_sfr.rd ? next_sfr_rdata : READ_UNMAPPED;
        end
    end

    // hit tells the core that a mapped register answered, since zero is
    // also a legal register value
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_sfr_hit <= 1'b0;
        end else begin
            o_sfr_hit <= i_sfr.rd & any_sel;
        end
    end

    // ********************************
    // masking
    // ********************************
    wire [7:0] first_req_bits = {i_first_group_req.timer3, 1'b0,
                                 i_first_group_req.comparator,
                                 i_first_group_req.counter_array,
                                 i_first_group_req.conversion_done,
                                 i_first_group_req.window_compare,
                                 i_first_group_req.port_match,
                                 i_first_group_req.serial_bus_a};
    wire [7:0] first_pend = first_req_bits & i_first_group_enable;

    wire timer5_req = i_second_group_req.timer5_low_overflow_flag
                    | i_second_group_req.timer5_high_overflow_flag;
    wire timer4_req = i_second_group_req.timer4_low_overflow_flag
                    | i_second_group_req.timer4_high_overflow_flag;
    wire timer5_pend = timer5_req & second_group_enable[BIT_TIMER5];
    wire timer4_pend = timer4_req & second_group_enable[BIT_TIMER4];
    wire serial_b_pend = i_second_group_req.serial_bus_b
                       & second_group_enable[BIT_SERIAL_BUS_B];
    wire temp_pend = i_second_group_req.temp_sensor
                   & second_group_enable[BIT_TEMP_SENSOR];
    wire [3:0] second_pend = {temp_pend, timer5_pend, timer4_pend, serial_b_pend};

    // ********************************
    // arbitration
    // ********************************
    // reserved bit 6 and bits 7:4 are never looked at, so stray writes there
    // cannot raise a phantom source
    function automatic logic [NUM_SOURCES-1:0] flatten(input logic [7:0] first,
                                                       input logic [7:0] second);
        flatten = {second[BIT_TEMP_SENSOR], second[BIT_TIMER5], second[BIT_TIMER4],
                   second[BIT_SERIAL_BUS_B], first[BIT_TIMER3], first[BIT_COMPARATOR],
                   first[BIT_COUNTER_ARRAY], first[BIT_CONVERSION_DONE],
                   first[BIT_WINDOW_COMPARE], first[BIT_PORT_MATCH],
                   first[BIT_SERIAL_BUS_A]};
    endfunction

    wire [NUM_SOURCES-1:0] pend_vec = flatten(first_pend, {4'h0, second_pend});
    wire [NUM_SOURCES-1:0] msb_vec = flatten(first_group_priority_high,
                                             second_group_priority_high);
    wire [NUM_SOURCES-1:0] lsb_vec = flatten(first_group_priority_low,
                                             second_group_priority_low);

    // ********************************
    // per-source level
    // ********************************
    localparam int LEVEL_BITS = 2;
    localparam int SOURCE_BITS = 4;

    // msb and lsb side by side give each source its level
    wire [LEVEL_BITS-1:0] src_level [NUM_SOURCES];

    for (genvar s = 0; s < NUM_SOURCES; s++) begin : g_level
        assign src_level[s] = {msb_vec[s], lsb_vec[s]};
    end

    // ********************************
    // level select
    // ********************************
    // one pending vector per level; a pending source shows up in exactly one of them
    wire [NUM_SOURCES-1:0] pend_at_level [NUM_LEVELS];
    wire [NUM_LEVELS-1:0] level_busy;
    wire [SOURCE_BITS-1:0] level_winner [NUM_LEVELS];

    // lowest set position, so the lowest source number wins a tie
    function automatic logic [SOURCE_BITS-1:0] lowest_index(
        input logic [NUM_SOURCES-1:0] v);
        logic [SOURCE_BITS-1:0] idx;
        idx = '0;
        for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = SOURCE_BITS'(i);
            end
        end
        return idx;
    endfunction

    // highest busy level; zero when nothing is pending, valid tells them apart
    function automatic logic [LEVEL_BITS-1:0] highest_level(
        input logic [NUM_LEVELS-1:0] busy);
        logic [LEVEL_BITS-1:0] lvl;
        lvl = '0;
        for (int l = 0; l < NUM_LEVELS; l++) begin
            if (busy[l]) begin
                lvl = LEVEL_BITS'(l);
            end
        end
        return lvl;
    endfunction

    for (genvar lv = 0; lv < NUM_LEVELS; lv++) begin : g_arb
        for (genvar s = 0; s < NUM_SOURCES; s++) begin : g_match
            assign pend_at_level[lv][s] = pend_vec[s] & (src_level[s] == LEVEL_BITS'(lv));
        end
        assign level_busy[lv] = |pend_at_level[lv];
        assign level_winner[lv] = lowest_index(pend_at_level[lv]);
    end

    wire [LEVEL_BITS-1:0] top_level = highest_level(level_busy);
    wire irq_req_t next_irq = {|level_busy, level_winner[top_level], top_level};

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_irq <= '0;
        end else begin
            o_irq <= next_irq;
        end
    end

endmodule

//--- tb/irq_source_model.sv
// interrupt source model: pending levels held as the bench commands them
module irq_source_model
    import irq_prio_pkg::*;
(
    input wire logic i_ref_clk, // system clock
    input wire logic i_sys_rst, // sync reset
    input wire logic [6:0] i_first_cmd, // first-group levels to raise
    input wire logic [5:0] i_second_cmd, // second-group flags to raise
    output first_group_req_t o_first_req, // to the block
    output second_group_req_t o_second_req // to the block
);
    timeunit 1ns;
    timeprecision 1ps;
    // registered so requests change just after an edge, as real flags do
    always_ff @(posedge i_ref_clk) begin
        o_first_req <= i_sys_rst ? '0 : i_first_cmd;
        o_second_req <= i_sys_rst ? '0 : i_second_cmd;
    end
endmodule

//--- tb/extended_irq_enable_priority_assertions.sv
// port checker for the extended interrupt enable and priority block
module extended_irq_enable_priority_checker
    import irq_prio_pkg::*;
(
    input wire logic i_ref_clk, // clock
    input wire logic i_sys_rst, // reset
    input wire sfr_access_t i_sfr, // register access
    input wire logic [7:0] i_first_group_enable, // first enables
    input wire first_group_req_t i_first_group_req, // first requests
    input wire second_group_req_t i_second_group_req, // second flags
    input wire logic [7:0] o_sfr_rdata, // read data
    input wire logic o_sfr_hit, // read hit
    input wire irq_req_t o_irq // winner
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] en2;
    wire logic hit_en = i_sfr.addr == ADDR_SECOND_GROUP_ENABLE;
    wire logic nof = i_first_group_req == '0;
    wire logic mapped = i_sfr.addr inside {ADDR_FIRST_GROUP_PRIORITY_HIGH,
        ADDR_SECOND_GROUP_PRIORITY_HIGH, ADDR_SECOND_GROUP_ENABLE,
        ADDR_SECOND_GROUP_PRIORITY_LOW, ADDR_FIRST_GROUP_PRIORITY_LOW};
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    // shadow of the enable register, the only state the masking checks need
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) en2 <= '0;
        else if (i_sfr.wr && hit_en) en2 <= i_sfr.wdata;
    end
    sequence s_wr_rd;
        i_sfr.wr && hit_en ##1 i_sfr.rd && !i_sfr.wr && hit_en;
    endsequence
    a_read_hit: assert property (i_sfr.rd && mapped |=> o_sfr_hit)
        else $error("mapped read gave no hit");
    a_unmapped_quiet: assert property (i_sfr.rd && !mapped
        |=> !o_sfr_hit && o_sfr_rdata == READ_UNMAPPED)
        else $error("unmapped read answered");
    a_idle_read_zero: assert property (!i_sfr.rd
        |=> !o_sfr_hit && o_sfr_rdata == READ_UNMAPPED)
        else $error("read data without read");
    a_write_readback: assert property (s_wr_rd
        |=> o_sfr_rdata == $past(i_sfr.wdata, 2))
        else $error("enable register readback wrong");
    a_no_request: assert property (nof && i_second_group_req == '0 |=> !o_irq.valid)
        else $error("request without source");
    a_masked_none: assert property (nof && en2[3:0] == 4'h0
        |=> !o_irq.valid)
        else $error("masked second-group request passed");
    a_timer5_pass: assert property (nof && en2[2]
        && i_second_group_req inside {6'h10, 6'h08}
        |=> o_irq.valid && o_irq.source == SRC_TIMER5)
        else $error("timer5 request lost");
    a_timer4_pass: assert property (nof && en2[1]
        && i_second_group_req inside {6'h04, 6'h02}
        |=> o_irq.valid && o_irq.source == SRC_TIMER4)
        else $error("timer4 request lost");
endmodule
bind extended_irq_enable_priority extended_irq_enable_priority_checker chk (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_sfr(i_sfr),
    .i_first_group_enable(i_first_group_enable),
    .i_first_group_req(i_first_group_req),
    .i_second_group_req(i_second_group_req),
    .o_sfr_rdata(o_sfr_rdata),
    .o_sfr_hit(o_sfr_hit),
    .o_irq(o_irq)
);

//--- tb/test_extended_irq_enable_priority.sv
// self-checking bench for the extended interrupt enable and priority block
module test_extended_irq_enable_priority
    import irq_prio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ADDRS [5] = '{8'h85, 8'h86, 8'haf, 8'hbf, 8'hf6};
    localparam logic [7:0] VALS [5] = '{8'hb5, 8'h0a, 8'h05, 8'h0c, 8'h8a};
    localparam int BITS [6] = '{3, 2, 2, 1, 1, 0};
    localparam logic [3:0] SRCS [6] = '{SRC_TEMP_SENSOR, SRC_TIMER5, SRC_TIMER5,
        SRC_TIMER4, SRC_TIMER4, SRC_SERIAL_BUS_B};
    localparam logic [7:0] HI2 = 8'h05;
    logic i_ref_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    sfr_access_t sfr = '0;
    logic [7:0] first_en = 8'h00;
    logic [6:0] first_cmd = '0;
    logic [5:0] second_cmd = '0;
    first_group_req_t first_req;
    second_group_req_t second_req;
    logic [7:0] rdata;
    logic hit;
    irq_req_t irq;
    int mismatches = 0;
    int checks_done = 0;
    always #4 i_ref_clk = ~i_ref_clk;
    irq_source_model src (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_first_cmd(first_cmd),
        .i_second_cmd(second_cmd), .o_first_req(first_req), .o_second_req(second_req));
    extended_irq_enable_priority uut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_sfr(sfr),
        .i_first_group_enable(first_en), .i_first_group_req(first_req),
        .i_second_group_req(second_req), .o_sfr_rdata(rdata), .o_sfr_hit(hit), .o_irq(irq));
    // ****************************************
    // bus and compare tasks
    // ****************************************
    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // write strobe is left up one cycle; the next task's edge drops it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk) sfr <= '{1'b1, 1'b0, a, d};
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input logic exph);
        @(posedge i_ref_clk) sfr <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge i_ref_clk) sfr <= '0;
        #1;
        check("rdata", rdata, exp);
        check("hit", {7'h00, hit}, {7'h00, exph});
    endtask
    // one edge into the source model, one into the arbiter, one to settle
    task automatic req(input logic [6:0] f, input logic [5:0] s, input logic [6:0] exp);
        @(posedge i_ref_clk) sfr <= '0;
        first_cmd <= f;
        second_cmd <= s;
        repeat (3) @(posedge i_ref_clk);
        #1;
        check("irq", {1'b0, irq}, {1'b0, exp});
    endtask
    task automatic t_regs;
        rdc(8'h90, READ_UNMAPPED, 1'b0);
        foreach (ADDRS[i]) rdc(ADDRS[i], REG_RESET, 1'b1);
        foreach (ADDRS[i]) begin
            wr(ADDRS[i], VALS[i]);
            rdc(ADDRS[i], VALS[i], 1'b1);
        end
        wr(8'h90, 8'hff);
        rdc(8'h90, READ_UNMAPPED, 1'b0);
    endtask
    task automatic t_mask;
        wr(ADDR_SECOND_GROUP_PRIORITY_LOW, 8'h0f);
        wr(ADDR_SECOND_GROUP_PRIORITY_HIGH, HI2);
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_SECOND_GROUP_ENABLE, 8'h0f & ~(8'h01 << BITS[i]));
            req(7'h00, 6'h20 >> i, 7'h00);
            wr(ADDR_SECOND_GROUP_ENABLE, 8'h01 << BITS[i]);
            req(7'h00, 6'h20 >> i, {1'b1, SRCS[i], HI2[BITS[i]], 1'b1});
        end
        req(7'h00, 6'h00, 7'h00);
    endtask
    task automatic t_prio;
        @(posedge i_ref_clk) first_en <= 8'hbf;
        wr(ADDR_FIRST_GROUP_PRIORITY_LOW, 8'h80);
        wr(ADDR_FIRST_GROUP_PRIORITY_HIGH, 8'h01);
        wr(ADDR_SECOND_GROUP_ENABLE, 8'h0f);
        req(7'h41, 6'h02, {1'b1, SRC_SERIAL_BUS_A, 2'h2});
        req(7'h41, 6'h12, {1'b1, SRC_TIMER5, 2'h3});
        req(7'h40, 6'h02, {1'b1, SRC_TIMER3, 2'h1});
        @(posedge i_ref_clk) first_en <= 8'h00;
        req(7'h40, 6'h02, {1'b1, SRC_TIMER4, 2'h1});
    endtask
    // a reset in mid-run must drop a standing request and clear the registers
    task automatic t_reset;
        wr(ADDR_SECOND_GROUP_ENABLE, 8'h04);
        req(7'h00, 6'h08, {1'b1, SRC_TIMER5, 2'h3});
        @(posedge i_ref_clk) i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        #1;
        check("irq in reset", {1'b0, irq}, 8'h00);
        @(posedge i_ref_clk) i_sys_rst <= 1'b0;
        rdc(ADDR_SECOND_GROUP_ENABLE, REG_RESET, 1'b1);
        rdc(ADDR_SECOND_GROUP_PRIORITY_HIGH, REG_RESET, 1'b1);
        req(7'h00, 6'h08, 7'h00);
    endtask
    task automatic results;
        if (mismatches == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        t_regs;
        t_mask;
        t_prio;
        t_reset;
        results;
    end
    initial begin
        #100000;
        mismatches++;
        results;
    end
endmodule
